/* File: etc_pkg.sv */
// Purpose: Constants for the edge timing control block
// Assumes: 32-bit register port, one clock core_clk at 20 MHz
// Notes:   Offsets are word indices times four
package etc_pkg;
  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0]  ADDR_CMP_STATUS = 8'h00;
  localparam logic [7:0]  ADDR_MEAS_CTRL  = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0C;
  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int CMP_IDLE_STOP_BIT    = 13;
  localparam int EDGE1_SEEN_BIT       = 24;
  localparam int EDGE2_MODE_BIT       = 23;
  localparam int EDGE2_POL_BIT        = 22;
  localparam int EDGE2_SEL_LSB        = 18;
  localparam int MEAS_ENABLE_BIT      = 15;
  localparam int MEAS_IDLE_STOP_BIT   = 13;
  localparam int DELAY_GEN_BIT        = 12;
  localparam int EDGE_PASS_BIT        = 11;
  // Writable bits of the control register
  localparam logic [31:0] MEAS_CTRL_WMASK = 32'h01FCB800;
  localparam logic [31:0] MEAS_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CMP_STATUS_RESET = 32'h00000000;
  // Interrupt status bits
  localparam int IRQ_EDGE2_BIT = 0;
  localparam int IRQ_EDGE1_BIT = 1;
  localparam int IRQ_WIDTH     = 2;
  // ***************************************************
  // Edge 2 source codes
  // ***************************************************
  localparam logic [3:0] SEL_CMP3     = 4'hF;
  localparam logic [3:0] SEL_CMP2     = 4'hE;
  localparam logic [3:0] SEL_CMP1     = 4'hD;
  localparam logic [3:0] SEL_BUS_CLK  = 4'hC;
  localparam logic [3:0] SEL_CAP3     = 4'hB;
  localparam logic [3:0] SEL_CAP2     = 4'hA;
  localparam logic [3:0] SEL_CAP1     = 4'h9;
  localparam logic [3:0] SEL_PIN13    = 4'h8;
  localparam logic [3:0] SEL_PIN12    = 4'h7;
  localparam logic [3:0] SEL_PIN11    = 4'h6;
  localparam logic [3:0] SEL_PIN10    = 4'h5;
  localparam logic [3:0] SEL_PIN9     = 4'h4;
  localparam logic [3:0] SEL_PIN1     = 4'h3;
  localparam logic [3:0] SEL_PIN2     = 4'h2;
  localparam logic [3:0] SEL_CMP_UNIT = 4'h1;
  localparam logic [3:0] SEL_TMR_UNIT = 4'h0;
  // Delay generation length in cycles
  localparam logic [7:0] DELAY_CYCLES = 8'h10;
endpackage

/* File: etc_edge_detect.sv */
// Purpose: Edge or level detection of the selected edge 2 source
// Assumes: Source is synchronous to core_clk
// Notes:   Pulse output in edge mode, level output in level mode
`timescale 1ns/1ps
module etc_edge_detect
  import etc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Control
  input  wire logic edge_mode,
  input  wire logic polarity,
  // Source and result
  input  wire logic src,
  output logic      hit
);
  logic src_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      src_reg <= 1'b0;
    end else begin
      src_reg <= src;
    end
  end

  // Edge or level, then polarity
  always_comb begin
    if (edge_mode) begin
      hit = polarity ? (src & ~src_reg) : (~src & src_reg);
    end else begin
      hit = polarity ? src : ~src;
    end
  end
endmodule

/* File: etc_top.sv */
// Purpose: Edge timing control and comparator status registers
// Assumes: Register port with read data one cycle after read strobe
// Notes:   Functional notes
// Functional notes
// - Comparator idle stop bit 13 disables all comparators in idle mode
// - Status bits 2..0 read comparator 3..1 levels, read only, zero at reset
// - Unused comparator status bits read zero and ignore writes
// - Edge1 seen bit 24 reads one after edge 1, software writable
// - Bit 23 selects edge sensitive (1) or level sensitive (0) edge 2
// - Bit 22 selects positive (1) or negative (0) edge 2 response
// - Source codes F..9: comparators, bus clock, capture events
// - Source codes 8..0: external pins, compare event, timer event
// - Bit 15 enables the measurement unit
// - Bit 13 halts the measurement unit during idle mode
// - Bit 12 enables edge delay generation
// - Bit 11 passes edges when one, blocks all edges when zero
// - Control bits 17..16 and 14 read zero
`timescale 1ns/1ps
module etc_top
  import etc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Device state
  input  wire logic        idle_mode,
  // Edge sources
  input  wire logic [2:0]  comparator_result,
  input  wire logic        periph_bus_clock,
  input  wire logic [2:0]  capture_event,
  input  wire logic        compare_unit_1_event,
  input  wire logic        timer_unit_1_event,
  input  wire logic        edge1_source,
  input  wire logic [4:0]  ext_edge_pin_hi,
  input  wire logic        ext_edge_pin_1,
  input  wire logic        ext_edge_pin_2,
  // Outputs
  output logic             comparator_enable,
  output logic             meas_active,
  output logic             edge2_event,
  output logic             delay_pulse,
  output logic             irq
);
  // ***************************************************
  // Registers
  // ***************************************************
  logic        cmp_idle_stop_reg;
  logic [2:0]  cmp_result_reg;
  logic [31:0] ctrl_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic [7:0]  delay_cnt_reg;
  logic        edge1_prev_reg;
  logic [31:0] rdata_next;
  logic        edge2_src;
  logic        edge2_hit;
  logic        edges_ok;
  logic        edge1_rise;
  logic [IRQ_WIDTH-1:0] irq_set;

  // Strobe qualified by one register address
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  wire wr_cmp  = addr_hit(reg_wr, reg_addr, ADDR_CMP_STATUS);
  wire wr_ctrl = addr_hit(reg_wr, reg_addr, ADDR_MEAS_CTRL);
  wire wr_mask = addr_hit(reg_wr, reg_addr, ADDR_IRQ_MASK);
  wire rd_irq  = addr_hit(reg_rd, reg_addr, ADDR_IRQ_STATUS);

  // ***************************************************
  // Comparator status
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmp_idle_stop_reg <= 1'b0;
    end else if (wr_cmp) begin
      cmp_idle_stop_reg <= reg_wdata[CMP_IDLE_STOP_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmp_result_reg <= 3'h0;
    end else begin
      cmp_result_reg <= comparator_result;
    end
  end

  assign comparator_enable = !(cmp_idle_stop_reg && idle_mode);

  // ***************************************************
  // Measurement control
  // ***************************************************
  assign meas_active = ctrl_reg[MEAS_ENABLE_BIT]
                       && !(ctrl_reg[MEAS_IDLE_STOP_BIT] && idle_mode);
  assign edges_ok = meas_active && ctrl_reg[EDGE_PASS_BIT];
  assign edge1_rise = edge1_source && !edge1_prev_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      edge1_prev_reg <= 1'b0;
    end else begin
      edge1_prev_reg <= edge1_source;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= MEAS_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata & MEAS_CTRL_WMASK;
      end
      if (edges_ok && edge1_rise) begin
        ctrl_reg[EDGE1_SEEN_BIT] <= 1'b1;
      end
    end
  end

  // ***************************************************
  // Edge 2 source select
  // ***************************************************
  always_comb begin
    unique case (ctrl_reg[EDGE2_SEL_LSB +: 4])
      SEL_CMP3:     edge2_src = cmp_result_reg[2];
      SEL_CMP2:     edge2_src = cmp_result_reg[1];
      SEL_CMP1:     edge2_src = cmp_result_reg[0];
      SEL_BUS_CLK:  edge2_src = periph_bus_clock;
      SEL_CAP3:     edge2_src = capture_event[2];
      SEL_CAP2:     edge2_src = capture_event[1];
      SEL_CAP1:     edge2_src = capture_event[0];
      SEL_PIN13:    edge2_src = ext_edge_pin_hi[4];
      SEL_PIN12:    edge2_src = ext_edge_pin_hi[3];
      SEL_PIN11:    edge2_src = ext_edge_pin_hi[2];
      SEL_PIN10:    edge2_src = ext_edge_pin_hi[1];
      SEL_PIN9:     edge2_src = ext_edge_pin_hi[0];
      SEL_PIN1:     edge2_src = ext_edge_pin_1;
      SEL_PIN2:     edge2_src = ext_edge_pin_2;
      SEL_CMP_UNIT: edge2_src = compare_unit_1_event;
      SEL_TMR_UNIT: edge2_src = timer_unit_1_event;
    endcase
  end

  etc_edge_detect u_edge2 (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .edge_mode (ctrl_reg[EDGE2_MODE_BIT]),
    .polarity  (ctrl_reg[EDGE2_POL_BIT]),
    .src       (edge2_src),
    .hit       (edge2_hit)
  );

  assign edge2_event = edge2_hit && edges_ok;

  // ***************************************************
  // Delay generation
  // ***************************************************
  // Starts on edge 1; a new edge 1 restarts the count
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      delay_cnt_reg <= 8'h00;
    end else if (!ctrl_reg[DELAY_GEN_BIT] || !edges_ok) begin
      delay_cnt_reg <= 8'h00;
    end else if (edge1_rise) begin
      delay_cnt_reg <= DELAY_CYCLES;
    end else if (delay_cnt_reg != 8'h00) begin
      delay_cnt_reg <= delay_cnt_reg - 8'h01;
    end
  end

  assign delay_pulse = (delay_cnt_reg == 8'h01);

  // ***************************************************
  // Interrupts
  // ***************************************************
  assign irq_set = {edges_ok && edge1_rise, edge2_event};

  // Set wins over the clear by read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_status_reg <= '0;
    end else if (rd_irq) begin
      irq_status_reg <= irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ***************************************************
  // Read port
  // ***************************************************
  always_comb begin
    rdata_next = 32'h00000000;
    unique case (reg_addr)
      ADDR_CMP_STATUS: begin
        rdata_next[CMP_IDLE_STOP_BIT] = cmp_idle_stop_reg;
        rdata_next[2:0] = cmp_result_reg;
      end
      ADDR_MEAS_CTRL:  rdata_next = ctrl_reg & MEAS_CTRL_WMASK;
      ADDR_IRQ_STATUS: rdata_next[IRQ_WIDTH-1:0] = irq_status_reg;
      ADDR_IRQ_MASK:   rdata_next[IRQ_WIDTH-1:0] = irq_mask_reg;
      default:         rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ***************************************************
  // Checks: comparator status
  // ***************************************************
  cmp_idle_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (cmp_idle_stop_reg && idle_mode) |-> !comparator_enable)
    else $error("comparator runs in idle with stop set");
  cmp_idle_run_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !cmp_idle_stop_reg |-> comparator_enable)
    else $error("comparator stopped without idle stop");
  cmp_result_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reg_rd && reg_addr == ADDR_CMP_STATUS
    |=> reg_rdata[2:0] == $past(cmp_result_reg))
    else $error("comparator level read wrong");
  cmp_unused_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reg_rd && reg_addr == ADDR_CMP_STATUS
    |=> reg_rdata[31:14] == 18'h0 && reg_rdata[12:3] == 10'h0)
    else $error("unused comparator bits nonzero");
  cmp_stop_wr_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_cmp |=> cmp_idle_stop_reg == $past(reg_wdata[CMP_IDLE_STOP_BIT]))
    else $error("comparator idle stop not written");

  // ***************************************************
  // Checks: register port
  // ***************************************************
  rdata_idle_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data stands past its cycle");
  ctrl_zero_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ctrl_reg[17:16] == 2'h0 && !ctrl_reg[14])
    else $error("unused control bits set");
  ctrl_read_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reg_rd && reg_addr == ADDR_MEAS_CTRL
    |=> reg_rdata[17:16] == 2'h0 && !reg_rdata[14])
    else $error("unused control bits read nonzero");

  // ***************************************************
  // Checks: measurement control and edges
  // ***************************************************
  meas_on_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ctrl_reg[MEAS_ENABLE_BIT] || (ctrl_reg[MEAS_IDLE_STOP_BIT] && idle_mode)
    |-> !meas_active)
    else $error("unit active while off or idle");
  meas_run_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ctrl_reg[MEAS_ENABLE_BIT] && !ctrl_reg[MEAS_IDLE_STOP_BIT]
    |-> meas_active)
    else $error("unit inactive while enabled");
  edge1_set_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    edges_ok && edge1_rise |=> ctrl_reg[EDGE1_SEEN_BIT])
    else $error("edge 1 flag not set");
  edge1_wr_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_ctrl && !(edges_ok && edge1_rise)
    |=> ctrl_reg[EDGE1_SEEN_BIT] == $past(reg_wdata[EDGE1_SEEN_BIT]))
    else $error("edge 1 flag write lost");
  edge1_block_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !edges_ok && !wr_ctrl |=> $stable(ctrl_reg[EDGE1_SEEN_BIT]))
    else $error("edge 1 flag changed while blocked");
  edge2_block_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ctrl_reg[EDGE_PASS_BIT] |-> !edge2_event)
    else $error("edge 2 passed while blocked");
  edge2_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !meas_active |-> !edge2_event)
    else $error("edge 2 passed while unit off");
  edge2_pos_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    edge2_event && ctrl_reg[EDGE2_MODE_BIT] && ctrl_reg[EDGE2_POL_BIT]
    |-> edge2_src && !$past(edge2_src))
    else $error("edge 2 fired without rising edge");
  edge2_neg_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    edge2_event && ctrl_reg[EDGE2_MODE_BIT] && !ctrl_reg[EDGE2_POL_BIT]
    |-> !edge2_src && $past(edge2_src))
    else $error("edge 2 fired without falling edge");
  edge2_level_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    edges_ok && !ctrl_reg[EDGE2_MODE_BIT]
    |-> edge2_event == (edge2_src == ctrl_reg[EDGE2_POL_BIT]))
    else $error("edge 2 level response wrong");

  // ***************************************************
  // Checks: delay generation and interrupts
  // ***************************************************
  delay_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ctrl_reg[DELAY_GEN_BIT] |=> delay_cnt_reg == 8'h00)
    else $error("delay runs while disabled");
  delay_load_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ctrl_reg[DELAY_GEN_BIT] && edges_ok && edge1_rise
    |=> delay_cnt_reg == DELAY_CYCLES)
    else $error("delay count not loaded on edge 1");
  delay_once_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    delay_pulse |=> !delay_pulse)
    else $error("delay pulse longer than a cycle");
  irq_keep_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !rd_irq && irq_status_reg[IRQ_EDGE1_BIT]
    |=> irq_status_reg[IRQ_EDGE1_BIT])
    else $error("edge 1 interrupt lost");
  irq_clear_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_irq && irq_set == '0 |=> irq_status_reg == '0)
    else $error("interrupt status not cleared by read");

  edge2_seen_c: cover property (@(posedge core_clk) edge2_event);
  edge1_seen_c: cover property (@(posedge core_clk)
    edges_ok && edge1_rise);
  delay_done_c: cover property (@(posedge core_clk) delay_pulse);
  irq_raise_c:  cover property (@(posedge core_clk) irq);
  irq_clear_c:  cover property (@(posedge core_clk) rd_irq && irq);
endmodule

/* File: etc_src_model.sv */
// Purpose: Model of the comparator, capture, compare and timer sources
// Assumes: One source at a time is driven, picked by its select code
// Notes:   Sources not picked rest low
`timescale 1ns/1ps
module etc_src_model
  import etc_pkg::*;
(
  // Control from the bench
  input  wire logic [3:0] code,
  input  wire logic       lvl,
  // Source lines
  output logic [2:0]      cmp,
  output logic            bus_clk,
  output logic [2:0]      cap,
  output logic            cmpu,
  output logic            tmr,
  output logic [4:0]      pin_hi,
  output logic            pin1,
  output logic            pin2
);
  // ***************************************************
  // One-hot source lines, bit index equals select code
  // ***************************************************
  logic [15:0] hot;
  assign hot    = {15'h0000, lvl} << code;
  assign cmp    = hot[15:13];
  assign bus_clk = hot[12];
  assign cap    = hot[11:9];
  assign pin_hi = hot[8:4];
  assign pin1   = hot[3];
  assign pin2   = hot[2];
  assign cmpu   = hot[1];
  assign tmr    = hot[0];
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the edge timing control block
// Assumes: Read data stand in the cycle after the read strobe
// Notes:   Edge 2 sources and comparator levels come from the partner model, edge 1 source from the bench
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
  import etc_pkg::*;
;
  logic        core_clk, resetn, reg_wr, reg_rd, idle_mode, edge1_source;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, got;
  logic [3:0]  code;
  logic        lvl;
  wire  [31:0] reg_rdata;
  wire  [2:0]  cmp, cap;
  wire  [4:0]  pin_hi;
  wire         bus_clk, cmpu, tmr, pin1, pin2;
  wire         comparator_enable, meas_active, edge2_event, delay_pulse, irq;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cnt;
  etc_src_model u_src (.code(code), .lvl(lvl), .cmp(cmp), .bus_clk(bus_clk),
    .cap(cap), .cmpu(cmpu), .tmr(tmr), .pin_hi(pin_hi), .pin1(pin1),
    .pin2(pin2));
  etc_top u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .idle_mode(idle_mode), .comparator_result(cmp),
    .periph_bus_clock(bus_clk), .capture_event(cap),
    .compare_unit_1_event(cmpu), .timer_unit_1_event(tmr),
    .edge1_source(edge1_source), .ext_edge_pin_hi(pin_hi),
    .ext_edge_pin_1(pin1), .ext_edge_pin_2(pin2),
    .comparator_enable(comparator_enable), .meas_active(meas_active),
    .edge2_event(edge2_event), .delay_pulse(delay_pulse), .irq(irq));
  // ***************************************************
  // Register port tasks
  // ***************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(got, e)
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] s, input logic m,
                                      input logic p);
    return 32'h00008800 | (32'(m) << EDGE2_MODE_BIT)
         | (32'(p) << EDGE2_POL_BIT) | (32'(s) << EDGE2_SEL_LSB);
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  // ***************************************************
  // Test sequence
  // ***************************************************
  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h00000000; idle_mode = 1'b0; edge1_source = 1'b0;
    code = 4'h0; lvl = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(ADDR_CMP_STATUS, CMP_STATUS_RESET);
    rdc(ADDR_MEAS_CTRL, MEAS_CTRL_RESET);
    `CHK(meas_active, 1'b0)
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000);
    wr(ADDR_CMP_STATUS, 32'hFFFFFFFF);
    rdc(ADDR_CMP_STATUS, 32'h00002000);
    `CHK(comparator_enable, 1'b1)
    idle_mode <= 1'b1;
    #60 `CHK(comparator_enable, 1'b0)
    wr(ADDR_CMP_STATUS, 32'h00000000);
    `CHK(comparator_enable, 1'b1)
    for (int i = 0; i < 3; i++) begin
      code <= 4'(13 + i);
      lvl  <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdc(ADDR_CMP_STATUS, 32'h1 << i);
    end
    lvl <= 1'b0;
    wr(ADDR_MEAS_CTRL, 32'hFFFFFFFF);
    rdc(ADDR_MEAS_CTRL, MEAS_CTRL_WMASK);
    `CHK(meas_active, 1'b0)
    idle_mode <= 1'b0;
    #60 `CHK(meas_active, 1'b1)
    wr(ADDR_MEAS_CTRL, 32'h00000000);
    `CHK(meas_active, 1'b0)
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_MEAS_CTRL, ctl(4'(c), 1'b0, 1'b1));
      code <= 4'(c);
      lvl  <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 `CHK(edge2_event, 1'b1)
      lvl <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 `CHK(edge2_event, 1'b0)
    end
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_MEAS_CTRL, ctl(SEL_PIN1, 1'b1, 1'(p)));
      code <= SEL_PIN1;
      @(posedge core_clk) lvl <= 1'b1;
      #1 `CHK(edge2_event, 1'(p))
      @(posedge core_clk) #1 `CHK(edge2_event, 1'b0)
      @(posedge core_clk) lvl <= 1'b0;
      #1 `CHK(edge2_event, 1'(1 - p))
      @(posedge core_clk) #1;
    end
    wr(ADDR_IRQ_MASK, 32'h00000003);
    rd(ADDR_IRQ_STATUS);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_MEAS_CTRL, ctl(SEL_PIN1, 1'b1, 1'b1) & (k ? 32'hFFFF7FFF
                                                        : 32'hFFFFF7FF));
      @(posedge core_clk) lvl <= 1'b1;
      #1 `CHK(edge2_event, 1'b0)
      @(posedge core_clk) edge1_source <= 1'b1;
      repeat (2) @(posedge core_clk);
      rdc(ADDR_IRQ_STATUS, 32'h00000000);
      rdc(ADDR_MEAS_CTRL, k ? 32'h00CC0800 : 32'h00CC8000);
      lvl <= 1'b0;
      edge1_source <= 1'b0;
    end
    wr(ADDR_MEAS_CTRL, 32'h00408800);
    @(posedge core_clk) edge1_source <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdc(ADDR_MEAS_CTRL, 32'h01408800);
    `CHK(irq, 1'b1)
    rdc(ADDR_IRQ_STATUS, 32'h00000002);
    `CHK(irq, 1'b0)
    wr(ADDR_MEAS_CTRL, 32'h00408800);
    rdc(ADDR_MEAS_CTRL, 32'h00408800);
    wr(ADDR_IRQ_MASK, 32'h00000000);
    edge1_source <= 1'b0;
    @(posedge core_clk) edge1_source <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STATUS);
    edge1_source <= 1'b0;
    wr(ADDR_MEAS_CTRL, 32'h00409800 | (32'(SEL_CMP2) << EDGE2_SEL_LSB));
    @(posedge core_clk) edge1_source <= 1'b1;
    cnt = 0;
    while (cnt < 40 && delay_pulse !== 1'b1) begin
      @(posedge core_clk) #1 cnt++;
    end
    `CHK(cnt, DELAY_CYCLES)
    @(posedge core_clk) #1 `CHK(delay_pulse, 1'b0)
    rd(ADDR_IRQ_STATUS);
    wr(ADDR_MEAS_CTRL, ctl(SEL_PIN1, 1'b1, 1'b1));
    lvl <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdc(ADDR_IRQ_STATUS, 32'h00000001);
    wr(ADDR_MEAS_CTRL, ctl(SEL_PIN1, 1'b0, 1'b0));
    `CHK(edge2_event, 1'b0)
    lvl <= 1'b0;
    #60 `CHK(edge2_event, 1'b1)
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(ADDR_MEAS_CTRL, MEAS_CTRL_RESET);
    `CHK(edge2_event, 1'b0)
    complete_run();
  end
endmodule
